//--- mxh_host.sv
// Host client for a 64-bit 10G MAC: transmit master, receive sink, media side.
// Assumes stream signals on clk_sys; transmit media clock and reset come from outside.
`default_nettype none
// How it works
// - PHY gives 64-bit receive data, 8-bit control and a receive media clock.
// - Receive media reset enters the MAC; MAC sends a transmit media reset out.
// - Integrator holds both path resets high until the client clock is stable.
// - All client signals launch and sample on the rising client clock edge.
// - Lane n is data bits 8n+7 to 8n; keep bit n qualifies lane n.
// - Client raises valid with data and keep in the same cycle.
// - Ready accepts a beat; client holds beat while ready is low (here send_stall drops valid in a body beat even then).
// - Client marks last beat with tlast for one beat and proper keep.
// - User high on last beat marks frame bad, an explicit abort.
// - Client sends 8-bit per-lane parity in keep lane order.
// - Receive has no ready; client takes every valid beat.
module mxh_host (
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              arst_n,
    // Frame request
    input  wire logic              send_go,
    input  wire logic [15:0]       send_beats,
    input  wire logic [2:0]        send_tail,
    input  wire logic              send_bad,
    input  wire logic              send_stall,
    output logic                   send_busy,
    // Path resets toward MAC
    output logic                   rx_path_rst,
    output logic                   tx_path_rst,
    // Transmit stream
    output mxh_pkg::mxh_beat_t     tx_beat,
    output logic                   tx_valid,
    input  wire logic              tx_ready,
    // Receive stream
    input  wire mxh_pkg::mxh_beat_t rx_beat,
    input  wire logic              rx_valid,
    // Receive results
    output logic                   rx_done,
    output logic                   rx_bad_q,
    output logic                   rx_par_err_q,
    output logic [15:0]            rx_len_q,
    output logic [15:0]            rx_frames_q,
    output logic [15:0]            rx_bad_frames_q,
    // Media side
    output mxh_pkg::mxh_mii_t      phy_rx_word,
    output logic                   phy_rx_clk,
    output logic                   phy_rx_rst,
    input  wire mxh_pkg::mxh_mii_t mac_tx_word,
    input  wire logic              mac_tx_clk,
    input  wire logic              mac_tx_rst,
    output mxh_pkg::mxh_mii_t      mac_tx_cap_q,
    output logic                   mac_tx_in_rst
);
    // ==================================================
    // Path resets
    // Held high until clk_sys runs, released two edges after arst_n rises
    logic [1:0] rst_sh_q;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rst_sh_q <= 2'b11;
        end else begin
            rst_sh_q <= {rst_sh_q[0], 1'b0};
        end
    end
    assign rx_path_rst = rst_sh_q[1];
    assign tx_path_rst = rst_sh_q[1];

    // ==================================================
    // Transmit beat source
    mxh_pkg::mxh_tx_st_t st_q;
    logic [15:0] left_q;
    logic [2:0]  tail_q;
    logic        bad_q;
    logic [63:0] pat_q;
    logic [7:0]  tx_par;
    logic        fire;

    mxh_par u_tx_par (
        .data (pat_q),
        .par  (tx_par)
    );

    assign fire      = tx_valid && tx_ready;
    assign send_busy = (st_q != mxh_pkg::TX_IDLE);

    // Valid drop mid-frame on request produces an implicit underrun abort
    assign tx_valid = ((st_q == mxh_pkg::TX_BODY) && !send_stall)
                      || (st_q == mxh_pkg::TX_LAST);

    always_comb begin
        tx_beat.data = pat_q;
        tx_beat.par  = tx_par;
        tx_beat.last = (st_q == mxh_pkg::TX_LAST);
        tx_beat.user = (st_q == mxh_pkg::TX_LAST) && bad_q;
        if (st_q == mxh_pkg::TX_LAST) begin
            tx_beat.keep = mxh_pkg::KEEP_ALL >> (3'd7 - tail_q);
        end else if (st_q == mxh_pkg::TX_BODY) begin
            tx_beat.keep = mxh_pkg::KEEP_ALL;
        end else begin
            tx_beat.keep = mxh_pkg::KEEP_NONE;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_q    <= mxh_pkg::TX_IDLE;
            left_q  <= mxh_pkg::LEN_RST;
            tail_q  <= 3'h0;
            bad_q   <= 1'b0;
        end else begin
            case (st_q)
                mxh_pkg::TX_IDLE: begin
                    if (send_go && !rst_sh_q[1]) begin
                        left_q  <= (send_beats == 16'h0000) ? 16'h0001 : send_beats;
                        tail_q  <= send_tail;
                        bad_q   <= send_bad;
                        st_q    <= (send_beats <= 16'h0001) ? mxh_pkg::TX_LAST
                                                            : mxh_pkg::TX_BODY;
                    end
                end
                mxh_pkg::TX_BODY: begin
                    if (fire) begin
                        left_q <= left_q - 16'h0001;
                        if (left_q == 16'h0002) begin
                            st_q <= mxh_pkg::TX_LAST;
                        end
                    end
                end
                mxh_pkg::TX_LAST: begin
                    if (fire) begin
                        st_q <= mxh_pkg::TX_GAP;
                    end
                end
                mxh_pkg::TX_GAP: begin
                    st_q <= mxh_pkg::TX_IDLE;
                end
                default: begin
                    st_q <= mxh_pkg::TX_IDLE;
                end
            endcase
        end
    end

    // Data only advances on acceptance so the beat holds while ready is low
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pat_q <= 64'h0706050403020100;
        end else if (fire) begin
            pat_q <= pat_q + 64'h0808080808080808;
        end
    end

    // ==================================================
    // Receive sink, always ready
    logic [7:0] rx_par;
    logic [15:0] acc_q;
    logic [3:0]  nbytes;

    mxh_par u_rx_par (
        .data (rx_beat.data),
        .par  (rx_par)
    );

    always_comb begin
        nbytes = 4'h0;
        for (int i = 0; i < mxh_pkg::LANES; i++) begin
            nbytes = nbytes + {3'h0, rx_beat.keep[i]};
        end
    end

    assign rx_done = rx_valid && rx_beat.last;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            acc_q           <= mxh_pkg::LEN_RST;
            rx_len_q        <= mxh_pkg::LEN_RST;
            rx_bad_q        <= 1'b0;
            rx_frames_q     <= mxh_pkg::LEN_RST;
            rx_bad_frames_q <= mxh_pkg::LEN_RST;
        end else if (rx_valid) begin
            if (rx_beat.last) begin
                acc_q       <= mxh_pkg::LEN_RST;
                rx_len_q    <= acc_q + {12'h000, nbytes};
                rx_frames_q <= rx_frames_q + 16'h0001;
                // Bad frames must be dropped by the user, only counted here
                rx_bad_q    <= rx_beat.user;
                if (rx_beat.user) begin
                    rx_bad_frames_q <= rx_bad_frames_q + 16'h0001;
                end
            end else begin
                acc_q <= acc_q + 16'h0008;
            end
        end
    end

    // Sticky until reset so a single flipped kept lane is never missed
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rx_par_err_q <= 1'b0;
        end else if (rx_valid && ((rx_par ^ rx_beat.par) & rx_beat.keep) != 8'h00) begin
            rx_par_err_q <= 1'b1;
        end
    end

    // ==================================================
    // Media side: PHY receive clock from a divider, idle word, PHY reset
    logic [1:0] div_q;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            div_q <= 2'h0;
        end else begin
            div_q <= div_q + 2'h1;
        end
    end
    assign phy_rx_clk = div_q[1];

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            phy_rx_rst  <= 1'b1;
            phy_rx_word <= '0;
        end else if (div_q == 2'h0) begin
            // Launch mid-low so the word is stable at the rising media edge
            phy_rx_rst  <= rst_sh_q[1];
            phy_rx_word <= '{d: 64'h0707070707070707, c: 8'hff};
        end
    end

    // Transmit media clock and reset are sampled, never used as clocks
    logic [2:0] tclk_q;
    logic [1:0] trst_q;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            tclk_q <= 3'h0;
            trst_q <= 2'b11;
        end else begin
            tclk_q <= {tclk_q[1:0], mac_tx_clk};
            trst_q <= {trst_q[0], mac_tx_rst};
        end
    end
    assign mac_tx_in_rst = trst_q[1];

    // Word is captured on a synchronised rising edge; it is slow enough to be stable
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mac_tx_cap_q <= '0;
        end else if (tclk_q[1] && !tclk_q[2]) begin
            mac_tx_cap_q <= mac_tx_word;
        end
    end

    // ==================================================
    // Checks
    a_hold_beat: assert property (@(posedge clk_sys) disable iff (!arst_n)
        tx_valid && !tx_ready |=> $stable(tx_beat.data))
        else $error("Beat changed while not ready");
    a_full_keep: assert property (@(posedge clk_sys) disable iff (!arst_n)
        tx_valid && !tx_beat.last |-> tx_beat.keep == 8'hff)
        else $error("Non-final beat lacks full keep");
    a_last_once: assert property (@(posedge clk_sys) disable iff (!arst_n)
        fire && tx_beat.last |=> !tx_valid)
        else $error("Last beat repeated");
    a_user_last: assert property (@(posedge clk_sys) disable iff (!arst_n)
        tx_beat.user |-> tx_beat.last)
        else $error("User set off the last beat");
    a_tx_parity: assert property (@(posedge clk_sys) disable iff (!arst_n)
        tx_valid |-> tx_beat.par == {^tx_beat.data[63:56], ^tx_beat.data[55:48],
            ^tx_beat.data[47:40], ^tx_beat.data[39:32], ^tx_beat.data[31:24],
            ^tx_beat.data[23:16], ^tx_beat.data[15:8], ^tx_beat.data[7:0]})
        else $error("Transmit parity wrong");
    a_keep_low: assert property (@(posedge clk_sys) disable iff (!arst_n)
        tx_beat.last |-> tx_beat.keep[0] && ((tx_beat.keep + 8'h01) & tx_beat.keep) == 8'h00)
        else $error("Final keep not contiguous from lane 0");
    a_rst_release: assert property (@(posedge clk_sys) disable iff (!arst_n)
        $rose(arst_n) |-> rx_path_rst)
        else $error("Path reset released too early");
    a_rst_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
        rx_path_rst |-> !tx_valid)
        else $error("Frame started under path reset");
    a_rx_count: assert property (@(posedge clk_sys) disable iff (!arst_n)
        rx_done |=> rx_frames_q == $past(rx_frames_q) + 16'h0001)
        else $error("Receive frame missed");
    a_bad_count: assert property (@(posedge clk_sys) disable iff (!arst_n)
        rx_done && rx_beat.user |=> rx_bad_frames_q == $past(rx_bad_frames_q) + 16'h0001)
        else $error("Bad receive frame not counted");
    a_word_still: assert property (@(posedge clk_sys) disable iff (!arst_n)
        div_q == 2'h1 |=> $stable({phy_rx_rst, phy_rx_word}))
        else $error("Media word changed at its rising clock edge");
endmodule : mxh_host
`default_nettype wire

//--- mxh_host_tb.sv
// Self-checking bench for the host client with a behavioural MAC model.
// Assumes clk_sys at 100 MHz; the bench stands in for the MAC receive stream.
`default_nettype none
module mxh_host_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys, arst_n, send_go, send_bad, send_stall, send_busy, slow;
    logic [15:0] send_beats, rx_len_q, rx_frames_q, rx_bad_frames_q, n_frames, n_bytes;
    logic [2:0] send_tail;
    logic rx_path_rst, tx_path_rst, tx_valid, tx_ready, rx_valid, rx_done, rx_bad_q;
    logic rx_par_err_q, phy_rx_clk, phy_rx_rst, mac_tx_clk, mac_tx_rst, mac_tx_in_rst;
    logic last_user, aborted, errs, pe;
    mxh_pkg::mxh_beat_t tx_beat, rx_beat;
    mxh_pkg::mxh_mii_t  phy_rx_word, mac_tx_word, mac_tx_cap_q;
    int                 n_mismatch, checks, seed, t0;
    mxh_host mxh_host_inst (.clk_sys, .arst_n, .send_go, .send_beats, .send_tail, .send_bad,
        .send_stall, .send_busy, .rx_path_rst, .tx_path_rst, .tx_beat, .tx_valid, .tx_ready,
        .rx_beat, .rx_valid, .rx_done, .rx_bad_q, .rx_par_err_q, .rx_len_q, .rx_frames_q,
        .rx_bad_frames_q, .phy_rx_word, .phy_rx_clk, .phy_rx_rst, .mac_tx_word, .mac_tx_clk,
        .mac_tx_rst, .mac_tx_cap_q, .mac_tx_in_rst);
    mxh_mac_model mxh_mac_model_inst (.clk_sys, .arst_n, .tx_beat, .tx_valid, .tx_ready,
        .slow, .n_frames, .n_bytes, .last_user, .aborted, .errs, .mac_tx_word, .mac_tx_clk,
        .mac_tx_rst);
    always #5 clk_sys = ~clk_sys;
    function automatic logic [7:0] lane_par(input logic [63:0] d);
        for (int n = 0; n < 8; n++) lane_par[n] = ^d[8*n +: 8];
    endfunction : lane_par
    // ==========
    // Compare and verdict
    task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wrap_up;
        if (n_mismatch == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up
    task automatic wait_idle;
        repeat (300) begin
            @(posedge clk_sys);
            #1;
            if (send_busy === 1'b0) break;
        end
        chk(send_busy, 1'b0);
    endtask : wait_idle
    // ==========
    // One transmit frame; go held g cycles, so extra cycles must be refused
    task automatic tx_frame(input int beats, input int tail, input logic bad, input logic sl,
                            input int g);
        logic [15:0] f0;
        f0 = n_frames;
        @(posedge clk_sys);
        send_beats <= beats[15:0];
        send_tail  <= tail[2:0];
        send_bad   <= bad;
        slow       <= sl;
        send_go    <= 1'b1;
        repeat (g) @(posedge clk_sys);
        send_go <= 1'b0;
        wait_idle();
        chk(n_frames, f0 + 16'h0001);
        chk(n_bytes, (beats - 1) * 8 + tail + 1);
        chk(last_user, bad);
    endtask : tx_frame
    // ==========
    // One receive frame in the MAC's place; perr flips lane 0 parity
    // Runts are always bad, whatever else the frame carries
    function automatic logic fr_bad(input int beats, input int tail, input logic bad);
        return bad || ((beats - 1) * 8 + tail + 1 < mxh_pkg::MIN_FRAME);
    endfunction : fr_bad
    task automatic rx_frame(input int beats, input int tail, input logic bad, input logic perr);
        logic [15:0] f0;
        logic [15:0] b0;
        logic [63:0] d;
        logic        eb;
        f0 = rx_frames_q;
        b0 = rx_bad_frames_q;
        eb = fr_bad(beats, tail, bad);
        pe = pe | perr;
        for (int i = 0; i < beats; i++) begin
            @(posedge clk_sys);
            d = {$random(seed), $random(seed)};
            rx_beat <= '{data: d,
                         keep: (i == beats - 1) ? 8'hff >> (7 - tail) : 8'hff,
                         last: i == beats - 1, user: eb && i == beats - 1,
                         par: lane_par(d) ^ {7'h00, perr}};
            rx_valid <= 1'b1;
        end
        #1;
        chk(rx_done, 1'b1);
        @(posedge clk_sys);
        rx_valid <= 1'b0;
        rx_beat  <= ~rx_beat;
        #1;
        chk(rx_len_q, (beats - 1) * 8 + tail + 1);
        chk(rx_bad_q, eb);
        chk(rx_frames_q, f0 + 16'h0001);
        chk(rx_bad_frames_q, b0 + 16'(eb));
        chk(rx_par_err_q, pe);
    endtask : rx_frame
    // ==========
    // Main sequence
    initial begin
        {clk_sys, arst_n, send_go, send_bad, send_stall, slow, rx_valid, pe} = '0;
        {send_beats, send_tail, rx_beat, n_mismatch, checks} = '0;
        seed = 85;
        repeat (6) @(posedge clk_sys);
        #1;
        chk({rx_path_rst, tx_path_rst, tx_valid}, 3'b110);
        @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        #1;
        chk({rx_path_rst, tx_path_rst}, 2'b00);
        tx_frame(1, 7, 1'b0, 1'b0, 1);
        tx_frame(1, 0, 1'b1, 1'b1, 1);
        tx_frame(5, 3, 1'b0, 1'b0, 3);
        for (int i = 0; i < 30; i++) begin
            tx_frame(1 + $unsigned($random(seed)) % 6, $unsigned($random(seed)) % 8,
                     $random(seed) & 1, $random(seed) & 1, 1);
        end
        chk({errs, aborted}, 2'b00);
        @(posedge clk_sys);
        send_beats <= 16'h0006;
        send_go    <= 1'b1;
        @(posedge clk_sys);
        send_go    <= 1'b0;
        repeat (2) @(posedge clk_sys);
        send_stall <= 1'b1;
        repeat (2) @(posedge clk_sys);
        send_stall <= 1'b0;
        wait_idle();
        chk(aborted, 1'b1);
        rx_frame(1, 0, 1'b0, 1'b0);
        rx_frame(3, 7, 1'b1, 1'b0);
        rx_frame(8, 7, 1'b0, 1'b0);
        for (int i = 0; i < 20; i++) begin
            rx_frame(1 + $unsigned($random(seed)) % 12, $unsigned($random(seed)) % 8,
                     $random(seed) & 1, 1'b0);
        end
        rx_frame(2, 4, 1'b0, 1'b1);
        @(posedge phy_rx_clk);
        t0 = $time;
        @(posedge phy_rx_clk);
        chk(($time - t0) / 10, mxh_pkg::MCLK_DIV);
        chk({phy_rx_rst, phy_rx_word.c}, {1'b0, 8'hff});
        @(posedge mac_tx_clk);
        repeat (6) @(posedge clk_sys);
        #1;
        chk(mac_tx_cap_q, mac_tx_word);
        chk(mac_tx_in_rst, 1'b0);
        wrap_up();
    end
    initial begin
        #500000;
        n_mismatch++;
        wrap_up();
    end
endmodule : mxh_host_tb
`default_nettype wire

//--- mxh_mac_model.sv
// Behavioural MAC model: transmit stream sink and transmit media port.
// Assumes the host launches stream signals on the rising edge of clk_sys.
`default_nettype none
module mxh_mac_model (
    // Clock and reset
    input  wire logic               clk_sys,
    input  wire logic               arst_n,
    // Transmit stream
    input  wire mxh_pkg::mxh_beat_t tx_beat,
    input  wire logic               tx_valid,
    output logic                    tx_ready,
    input  wire logic               slow,
    // Observed results
    output logic [15:0]             n_frames,
    output logic [15:0]             n_bytes,
    output logic                    last_user,
    output logic                    aborted,
    output logic                    errs,
    // Media side
    output mxh_pkg::mxh_mii_t       mac_tx_word,
    output logic                    mac_tx_clk,
    output logic                    mac_tx_rst
);
    timeunit 1ns;
    timeprecision 100ps;
    logic               in_frame;
    logic               hold;
    mxh_pkg::mxh_beat_t held;
    function automatic logic [7:0] lane_par(input logic [63:0] d);
        for (int n = 0; n < 8; n++) lane_par[n] = ^d[8*n +: 8];
    endfunction : lane_par
    // ==========
    // Stream sink; slow ready alternates so the host must hold its beats
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            tx_ready  <= 1'b0;
            hold      <= 1'b0;
            in_frame  <= 1'b0;
            n_frames  <= 16'h0000;
            n_bytes   <= 16'h0000;
            last_user <= 1'b0;
            aborted   <= 1'b0;
            errs      <= 1'b0;
        end else begin
            tx_ready <= slow ? ~tx_ready : 1'b1;
            hold     <= tx_valid && !tx_ready;
            held     <= tx_beat;
            if (hold && (!tx_valid || tx_beat !== held)) errs <= 1'b1;
            if (in_frame && !tx_valid) aborted <= 1'b1;
            if (tx_valid && tx_ready) begin
                if (tx_beat.par !== lane_par(tx_beat.data)) errs <= 1'b1;
                if (!tx_beat.last && tx_beat.keep !== 8'hff) errs <= 1'b1;
                if ((tx_beat.keep & (tx_beat.keep + 8'h01)) != 8'h00) errs <= 1'b1;
                n_bytes  <= (in_frame ? n_bytes : 16'h0000) + 16'($countones(tx_beat.keep));
                in_frame <= !tx_beat.last;
                if (tx_beat.last) begin
                    n_frames  <= n_frames + 16'h0001;
                    last_user <= tx_beat.user;
                end
            end
        end
    end
    // ==========
    // Media port; clock runs free, word advances on each rising edge
    initial begin
        mac_tx_clk = 1'b0;
        forever #62.5 mac_tx_clk = ~mac_tx_clk;
    end
    always_ff @(posedge mac_tx_clk or negedge arst_n) begin
        if (!arst_n) begin
            mac_tx_word <= '{d: 64'h0, c: 8'hff};
            mac_tx_rst  <= 1'b1;
        end else begin
            mac_tx_word <= '{d: mac_tx_word.d + 64'h1, c: mac_tx_word.d[7:0]};
            mac_tx_rst  <= 1'b0;
        end
    end
endmodule : mxh_mac_model
`default_nettype wire

//--- mxh_par.sv
// Per-lane even parity generator for one 64-bit beat.
// Pure combinational; used on both stream directions.
`default_nettype none
module mxh_par (
    // Data in
    input  wire logic [63:0] data,
    // Parity out
    output logic      [7:0]  par
);
    // ==================================================
    // Lane parity
    genvar g;
    generate
        for (g = 0; g < mxh_pkg::LANES; g++) begin : g_lane
            assign par[g] = ^data[8*g+7:8*g];
        end
    endgenerate
endmodule : mxh_par
`default_nettype wire

//--- mxh_pkg.sv
// Package for the host-side client of a 64-bit 10G MAC stream and media ports.
// Assumes one client clock; the transmit media clock arrives as an ordinary sampled input.
`default_nettype none
package mxh_pkg;
    // ==================================================
    // Widths and lanes
    localparam int          LANES      = 8;
    localparam int          DW         = 64;
    localparam int          CW         = 8;
    // ==================================================
    // Counts and reset values
    localparam int          MIN_FRAME  = 64;
    localparam logic [7:0]  KEEP_ALL   = 8'hff;
    localparam logic [7:0]  KEEP_NONE  = 8'h00;
    localparam logic [15:0] LEN_RST    = 16'h0000;
    localparam logic [15:0] TX_BEATS_D = 16'h0008;
    localparam int          MCLK_DIV   = 4;
    localparam int          RST_SYNC   = 2;

    // One stream beat
    typedef struct packed {
        logic [63:0] data;
        logic [7:0]  keep;
        logic        last;
        logic        user;
        logic [7:0]  par;
    } mxh_beat_t;

    // One media word
    typedef struct packed {
        logic [63:0] d;
        logic [7:0]  c;
    } mxh_mii_t;

    typedef enum logic [3:0] {
        TX_IDLE  = 4'b0001,
        TX_BODY  = 4'b0010,
        TX_LAST  = 4'b0100,
        TX_GAP   = 4'b1000
    } mxh_tx_st_t;
endpackage : mxh_pkg
`default_nettype wire
